//--- src/global_unique_identifier_load_latch.v
`include "identity_defines.vh"

// ==========================================================
// One identifier word that accepts a single load and then locks.
module global_unique_identifier_load_latch (
  input  wire        aclk,
  input  wire        bulk_clear,
  input  wire        nibble_clear,
  input  wire        load_en,
  input  wire [31:0] load_data,
  output reg  [31:0] value_reg,
  output reg         locked_reg
);

  // One process drives the whole word; the low nibble clear comes last so that it
  // overrides a load in the same cycle, while a fundamental reset alone spares it.
  // bulk clear
  always @(posedge aclk) begin
    if (bulk_clear) begin
      value_reg[31:`GLOBAL_UNIQUE_IDENTIFIER_NIBBLE_W] <= `GLOBAL_UNIQUE_IDENTIFIER_UPPER_RESET;
      locked_reg                   <= 1'b0;
    end else if (load_en && !locked_reg) begin
      value_reg                    <= load_data;
      locked_reg                   <= 1'b1;
    end
    if (nibble_clear) begin
      value_reg[`GLOBAL_UNIQUE_IDENTIFIER_NIBBLE_W-1:0] <= `GLOBAL_UNIQUE_IDENTIFIER_NIBBLE_RESET;
    end
  end

endmodule // global_unique_identifier_load_latch

//--- src/identity_address_regs.v
// Notes on behaviour
// - Upper identifier word is write-once to software and resets to zero.
// - With EEPROM present, both identifier words load from it, then freeze.
// - Without EEPROM, firmware writes each identifier word once; later writes ignored.
// - Upper word bits 31..4 clear on fundamental reset, global reset pin or power-on reset.
// - Identifier bits 3..0 clear only on global reset pin or power-on reset.
// - Lower word holds low identifier half, same reset, load and lock.
// - ROM base register is read-write, resets to zero.
// - ROM window reads map to base field plus ten low offset bits.
// - ROM base bits 9..0 always read zero.
// - Failed posted write captures low 32 destination offset bits.
// - Upper capture word holds requester bus and node numbers in 31..16.
// - Upper capture word bits 15..0 hold upper destination offset bits.
// - Capture words are read-only, hardware updated, no reset value.
// - Vendor word is read-only and returns a fixed code.
`include "identity_defines.vh"

module identity_address_regs #(
  // Arbitrary neutral value, not any real organisation's code.
  parameter [31:0] VENDOR_CODE = 32'h00ab_cdef
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        pcie_fundamental_reset_n,
  input  wire        global_reset_pin_n,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Serial EEPROM loader
  input  wire        eeprom_present,
  input  wire        eeprom_global_unique_identifier_valid,
  input  wire [31:0] eeprom_global_unique_identifier_upper,
  input  wire [31:0] eeprom_global_unique_identifier_lower,
  // Configuration ROM read mapping
  input  wire        rom_read_valid,
  input  wire [47:0] rom_read_offset,
  output reg         rom_host_read,
  output reg  [31:0] rom_host_addr,
  // Posted write failure report
  input  wire        post_err_valid,
  input  wire [47:0] post_err_offset,
  input  wire [15:0] post_err_source,
  // Status
  output wire [1:0]  global_unique_identifier_locked,
  output wire        irq
);

  // ==========================================================
  // Reset combination
  wire        power_on_clear;
  wire        bulk_clear;
  wire        nibble_clear;

  // The three reset sources nest: power-on clears everything but the capture words, the global reset pin
  // clears the whole identifier, and the fundamental reset spares the low nibble.
  // All are sampled levels, so each needs only one clock edge while low.
  assign power_on_clear = ~aresetn;
  assign nibble_clear   = power_on_clear | ~global_reset_pin_n;
  assign bulk_clear     = nibble_clear | ~pcie_fundamental_reset_n;

  // ==========================================================
  // AXI4-Lite write channel
  reg         aw_held_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire        wr_fire;
  reg         wr_mapped;

  // Address and data are parked separately so either may arrive first. Both readies
  // stay low while a response waits, which keeps one write in flight at a time.
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (power_on_clear) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= `WORD_ZERO;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Mapping is judged on the parked address, so the response matches its own write.
  always @* begin
    case ({aw_addr_reg[7:2], 2'b00})
      `GLOBAL_UNIQUE_IDENTIFIER_UPPER_OFFS,
      `GLOBAL_UNIQUE_IDENTIFIER_LOWER_OFFS,
      `ROM_BASE_OFFS,
      `FAIL_LOW_OFFS,
      `FAIL_HIGH_OFFS,
      `VENDOR_OFFS,
      `IRQ_STATUS_OFFS,
      `IRQ_MASK_OFFS: wr_mapped = 1'b1;
      default:        wr_mapped = 1'b0;
    endcase
  end

  // An unmapped address answers SLVERR; read-only words accept the write and drop it.
  always @(posedge aclk) begin
    if (power_on_clear) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  wire        wr_word;
  assign wr_word = wr_fire & (w_strb_reg == 4'hf);

  // ==========================================================
  // Write address decode
  // Only the word index takes part: byte-address bits 1..0 are ignored.
  wire [7:0]  wr_word_addr;
  wire        wr_rom_base;
  wire        wr_irq_status;
  wire        wr_irq_mask;

  assign wr_word_addr  = {aw_addr_reg[7:2], 2'b00};
  assign wr_rom_base   = wr_fire & (wr_word_addr == `ROM_BASE_OFFS);
  // Status and mask bits all sit in byte lane 0, so that lane alone enables the write.
  assign wr_irq_status = wr_fire & w_strb_reg[0] & (wr_word_addr == `IRQ_STATUS_OFFS);
  assign wr_irq_mask   = wr_fire & w_strb_reg[0] & (wr_word_addr == `IRQ_MASK_OFFS);

  // ==========================================================
  // Identifier words
  wire [31:0] global_unique_identifier_value [0:1];
  wire [31:0] eeprom_word [0:1];
  wire [7:0]  global_unique_identifier_offs [0:1];

  // Index 0 is the upper word and index 1 the lower word, matching global_unique_identifier_locked.
  assign eeprom_word[0] = eeprom_global_unique_identifier_upper;
  assign eeprom_word[1] = eeprom_global_unique_identifier_lower;
  assign global_unique_identifier_offs[0]   = `GLOBAL_UNIQUE_IDENTIFIER_UPPER_OFFS;
  assign global_unique_identifier_offs[1]   = `GLOBAL_UNIQUE_IDENTIFIER_LOWER_OFFS;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : global_unique_identifier_word
      wire load_en;
      wire [31:0] load_data;
      // single firmware load
      // A partial-strobe write cannot load, so a half-written identifier never locks.
      assign load_en   = eeprom_present ? eeprom_global_unique_identifier_valid
                                        : (wr_word & (wr_word_addr == global_unique_identifier_offs[gi]));
      assign load_data = eeprom_present ? eeprom_word[gi] : w_data_reg;
      global_unique_identifier_load_latch u_latch (
        .aclk         (aclk),
        .bulk_clear   (bulk_clear),
        .nibble_clear (nibble_clear),
        .load_en      (load_en),
        .load_data    (load_data),
        .value_reg    (global_unique_identifier_value[gi]),
        .locked_reg   (global_unique_identifier_locked[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Configuration ROM base and read mapping
  reg  [`ROM_BASE_W-1:0] rom_base_field_reg;
  wire [31:0]            rom_base_word;

  assign rom_base_word = {rom_base_field_reg, `ROM_LOW_ZERO};

  genvar bi;
  generate
    for (bi = 2; bi < 4; bi = bi + 1) begin : rom_lane
      always @(posedge aclk) begin
        if (power_on_clear) begin
          rom_base_field_reg[bi*8-`ROM_BASE_LSB +: 8] <= `ROM_LANE_RESET;
        end else if (wr_rom_base && w_strb_reg[bi]) begin
          rom_base_field_reg[bi*8-`ROM_BASE_LSB +: 8] <= w_data_reg[bi*8 +: 8];
        end
      end
    end
  endgenerate

  // Byte lane 1 carries only word bits 15..10 of the field; its bits 9..8 fall in the
  // zero pad and are dropped, as is all of lane 0.
  // software write lane 1
  always @(posedge aclk) begin
    if (power_on_clear) begin
      rom_base_field_reg[`ROM_LANE1_W-1:0] <= `ROM_LANE1_RESET;
    end else if (wr_rom_base && w_strb_reg[1]) begin
      rom_base_field_reg[`ROM_LANE1_W-1:0] <= w_data_reg[`ROM_BASE_LSB +: `ROM_LANE1_W];
    end
  end

  // Only offset bits 47..10 are compared, so every quadlet of the window hits.
  // The sum is not checked for carry: with base bits 9..0 zero it can never carry or wrap.
  wire rom_hit;
  assign rom_hit = rom_read_valid &
                   (rom_read_offset[`BUS_OFFSET_W-1:`ROM_BASE_LSB] == `ROM_WIN_TAG);

  // The address register holds its last value between hits; only the strobe pulses.
  // base plus low offset
  always @(posedge aclk) begin
    if (power_on_clear) begin
      rom_host_read <= 1'b0;
      rom_host_addr <= `WORD_ZERO;
    end else begin
      rom_host_read <= rom_hit;
      if (rom_hit) begin
        rom_host_addr <= rom_base_word + {22'h00_0000, rom_read_offset[`ROM_BASE_LSB-1:0]};
      end
    end
  end

  // ==========================================================
  // Posted write failure capture
  // The capture words carry no reset; software must not read them before the
  // first failure is flagged in the interrupt status.
  reg [31:0] failed_offset_low_reg;
  reg [31:0] failed_source_high_reg;

  always @(posedge aclk) begin
    if (post_err_valid) begin
      failed_offset_low_reg  <= post_err_offset[31:0];
      // upper offset capture
      // The source arrives as bus number in 15..6 and node number in 5..0.
      failed_source_high_reg <= {post_err_source, post_err_offset[`BUS_OFFSET_W-1:32]};
    end
  end

  // ==========================================================
  // Interrupt status and mask
  reg  [`IRQ_W-1:0] irq_status_reg;
  reg  [`IRQ_W-1:0] irq_mask_reg;
  wire [`IRQ_W-1:0] irq_set;
  wire [`IRQ_W-1:0] irq_clr;
  wire              global_unique_identifier_locked_all;
  reg               global_unique_identifier_locked_prev_reg;

  // Bit 1 fires once, when the second identifier word locks and the identifier is usable.
  assign global_unique_identifier_locked_all = &global_unique_identifier_locked;
  assign irq_set[`IRQ_POST_ERR_BIT]  = post_err_valid;
  assign irq_set[`IRQ_GLOBAL_UNIQUE_IDENTIFIER_LOCK_BIT] = global_unique_identifier_locked_all & ~global_unique_identifier_locked_prev_reg;
  assign irq_clr = wr_irq_status ? w_data_reg[`IRQ_W-1:0] : `IRQ_RESET;

  // A set in the same cycle as its clear wins, so no event is lost.
  always @(posedge aclk) begin
    if (power_on_clear) begin
      irq_status_reg       <= `IRQ_RESET;
      irq_mask_reg         <= `IRQ_RESET;
      global_unique_identifier_locked_prev_reg <= 1'b0;
    end else begin
      global_unique_identifier_locked_prev_reg <= global_unique_identifier_locked_all;
      irq_status_reg       <= (irq_status_reg & ~irq_clr) | irq_set;
      if (wr_irq_mask) begin
        irq_mask_reg <= w_data_reg[`IRQ_W-1:0];
      end
    end
  end

  // A plain level: it drops in the cycle after software clears or masks the bit.
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ==========================================================
  // AXI4-Lite read channel
  reg  [31:0] rd_word;
  reg         rd_mapped;

  // The read word is decoded straight from the bus address and registered at the
  // handshake, so a read answers one cycle after it is taken.
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_word   = `WORD_ZERO;
    rd_mapped = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `GLOBAL_UNIQUE_IDENTIFIER_UPPER_OFFS: rd_word = global_unique_identifier_value[0];
      `GLOBAL_UNIQUE_IDENTIFIER_LOWER_OFFS: rd_word = global_unique_identifier_value[1];
      `ROM_BASE_OFFS:   rd_word = rom_base_word;
      `FAIL_LOW_OFFS:   rd_word = failed_offset_low_reg;
      `FAIL_HIGH_OFFS:  rd_word = failed_source_high_reg;
      `VENDOR_OFFS:     rd_word = VENDOR_CODE;
      `IRQ_STATUS_OFFS: rd_word = {30'h0000_0000, irq_status_reg};
      `IRQ_MASK_OFFS:   rd_word = {30'h0000_0000, irq_mask_reg};
      default:          rd_mapped = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (power_on_clear) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `WORD_ZERO;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // identity_address_regs

//--- src/identity_defines.vh
`ifndef IDENTITY_DEFINES_VH
`define IDENTITY_DEFINES_VH

// ==========================================================
// Register byte offsets
`define GLOBAL_UNIQUE_IDENTIFIER_UPPER_OFFS   8'h24
`define GLOBAL_UNIQUE_IDENTIFIER_LOWER_OFFS   8'h28
`define ROM_BASE_OFFS     8'h34
`define FAIL_LOW_OFFS     8'h38
`define FAIL_HIGH_OFFS    8'h3c
`define VENDOR_OFFS       8'h40
`define IRQ_STATUS_OFFS   8'h48
`define IRQ_MASK_OFFS     8'h4c

// ==========================================================
// Widths, fields and reset values
`define GLOBAL_UNIQUE_IDENTIFIER_RESET        32'h0000_0000
`define GLOBAL_UNIQUE_IDENTIFIER_NIBBLE_W     4
`define GLOBAL_UNIQUE_IDENTIFIER_UPPER_RESET  28'h000_0000
`define GLOBAL_UNIQUE_IDENTIFIER_NIBBLE_RESET 4'h0
`define ROM_BASE_LSB      10
`define ROM_BASE_W        22
`define ROM_BASE_RESET    22'h00_0000
`define ROM_LANE_RESET    8'h00
`define ROM_LANE1_W       6
`define ROM_LANE1_RESET   6'h00
`define ROM_LOW_ZERO      10'h000
`define ROM_WIN_TAG       38'h3f_fffc_0001
`define BUS_OFFSET_W      48
`define SOURCE_W          16
`define IRQ_W             2
`define IRQ_POST_ERR_BIT  0
`define IRQ_GLOBAL_UNIQUE_IDENTIFIER_LOCK_BIT 1
`define IRQ_RESET         2'b00
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`define WORD_ZERO         32'h0000_0000

`endif

//--- test/identity_address_regs_asserts.sv
// ==========================================================
// Port-level checks of the identity and address register bank.
module identity_address_regs_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        pcie_fundamental_reset_n,
  input wire        global_reset_pin_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        eeprom_present,
  input wire        eeprom_global_unique_identifier_valid,
  input wire        rom_read_valid,
  input wire [47:0] rom_read_offset,
  input wire        rom_host_read,
  input wire [31:0] rom_host_addr,
  input wire [1:0]  global_unique_identifier_locked
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rom_hit;
    rom_read_valid && rom_read_offset[47:10] == 38'h3f_fffc_0001;
  endsequence
  property p_write_answer; s_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response mistimed");
  property p_write_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_write_busy: assert property (p_write_busy) else $error("write taken while response pending");
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  property p_read_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_read_busy: assert property (p_read_busy) else $error("read taken while data pending");
  property p_rom_hit; s_rom_hit |=> rom_host_read && rom_host_addr[9:0] == $past(rom_read_offset[9:0]); endproperty
  a_rom_hit: assert property (p_rom_hit) else $error("window read not mapped");
  property p_rom_miss; rom_read_valid && rom_read_offset[47:10] != 38'h3f_fffc_0001 |=> !rom_host_read; endproperty
  a_rom_miss: assert property (p_rom_miss) else $error("read outside window mapped");
  property p_lock_keep;
    pcie_fundamental_reset_n && global_reset_pin_n |=> (global_unique_identifier_locked & $past(global_unique_identifier_locked)) == $past(global_unique_identifier_locked);
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("identifier lock dropped");
  property p_eeprom_lock;
    eeprom_present && eeprom_global_unique_identifier_valid && pcie_fundamental_reset_n && global_reset_pin_n |=> global_unique_identifier_locked == 2'h3;
  endproperty
  a_eeprom_lock: assert property (p_eeprom_lock) else $error("loader did not lock");
  property p_reset_unlock; !pcie_fundamental_reset_n || !global_reset_pin_n |=> global_unique_identifier_locked == 2'h0; endproperty
  a_reset_unlock: assert property (p_reset_unlock) else $error("reset left a lock set");
endmodule // identity_address_regs_asserts

bind identity_address_regs identity_address_regs_asserts identity_address_regs_asserts_i (.*);

//--- test/identity_address_regs_bench.sv
module identity_address_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary neutral maker code for the fixed vendor word.
  localparam logic [31:0] VENDOR = 32'h0012_3456;
  logic        aclk = 1'h0, aresetn = 1'h0, pcie_fundamental_reset_n = 1'h1, global_reset_pin_n = 1'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, eeprom_present = 1'h0, eeprom_global_unique_identifier_valid = 1'h0;
  logic        rom_read_valid = 1'h0, post_err_valid = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, eeprom_global_unique_identifier_upper = 32'h0, eeprom_global_unique_identifier_lower = 32'h0;
  logic [47:0] rom_read_offset = 48'h0, post_err_offset = 48'h0;
  logic [15:0] post_err_source = 16'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, global_unique_identifier_locked, resp;
  logic [31:0] s_axi_rdata, rom_host_addr, rdat;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rom_host_read, irq, ta, tw, tb;
  int          fail_count = 0, comparisons = 0;

  identity_address_regs #(.VENDOR_CODE(VENDOR)) identity_address_regs_i (.*);

  always #4 aclk = ~aclk;

  // ==========================================================
  // Bus cycles and comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Ready is looked at on the falling edge, where it is settled for the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tb);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!tb);
    s_axi_rready <= 1'h0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
    chk(32'(resp), 32'h0);
  endtask

  task automatic rom_probe(input logic [47:0] o, input logic hit, input logic [31:0] a);
    @(posedge aclk);
    rom_read_offset <= o;
    rom_read_valid <= 1'h1;
    @(posedge aclk);
    rom_read_valid <= 1'h0;
    @(negedge aclk);
    chk(32'(rom_host_read), 32'(hit));
    if (hit) chk(rom_host_addr, a);
    @(negedge aclk);
    chk(32'(rom_host_read), 32'h0);
  endtask

  task automatic post_err(input logic [47:0] o, input logic [15:0] s);
    @(posedge aclk);
    post_err_offset <= o;
    post_err_source <= s;
    post_err_valid <= 1'h1;
    @(posedge aclk);
    post_err_valid <= 1'h0;
    @(negedge aclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    rchk(8'h24, 32'h0);
    rchk(8'h28, 32'h0);
    rchk(8'h34, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rchk(8'h40, VENDOR);
    rd(8'h80);
    chk(32'(resp), 32'h2);
    wr(8'h80, 32'h1);
    chk(32'(resp), 32'h2);
  endtask

  task automatic t_rom;
    wr(8'h34, 32'h1234_5678);
    rchk(8'h34, 32'h1234_5400);
    rom_probe(48'hffff_f000_0404, 1'h1, 32'h1234_5404);
    rom_probe(48'hffff_f000_07ff, 1'h1, 32'h1234_57ff);
    rom_probe(48'hffff_f000_0800, 1'h0, 32'h0);
  endtask

  task automatic t_firmware;
    wr(8'h24, 32'hdead_beef, 4'h3);
    rchk(8'h24, 32'h0);
    wr(8'h24, 32'haabb_ccd5);
    wr(8'h24, 32'h1111_1111);
    rchk(8'h24, 32'haabb_ccd5);
    wr(8'h28, 32'h0123_4567);
    wr(8'h28, 32'hffff_ffff);
    rchk(8'h28, 32'h0123_4567);
    @(negedge aclk);
    chk(32'(global_unique_identifier_locked), 32'h3);
  endtask

  // The low nibble survives the fundamental reset, so firmware values with odd nibbles are used.
  task automatic t_resets;
    @(posedge aclk);
    pcie_fundamental_reset_n <= 1'h0;
    @(posedge aclk);
    pcie_fundamental_reset_n <= 1'h1;
    rchk(8'h24, 32'h5);
    rchk(8'h28, 32'h7);
    global_reset_pin_n <= 1'h0;
    @(posedge aclk);
    global_reset_pin_n <= 1'h1;
    rchk(8'h24, 32'h0);
    rchk(8'h28, 32'h0);
    @(negedge aclk);
    chk(32'(global_unique_identifier_locked), 32'h0);
  endtask

  task automatic t_eeprom;
    @(posedge aclk);
    eeprom_present <= 1'h1;
    eeprom_global_unique_identifier_upper <= 32'h1357_9bdf;
    eeprom_global_unique_identifier_lower <= 32'h2468_ace0;
    eeprom_global_unique_identifier_valid <= 1'h1;
    @(posedge aclk);
    eeprom_global_unique_identifier_upper <= 32'hffff_ffff;
    eeprom_global_unique_identifier_lower <= 32'hffff_ffff;
    @(posedge aclk);
    eeprom_global_unique_identifier_valid <= 1'h0;
    wr(8'h24, 32'h0);
    rchk(8'h24, 32'h1357_9bdf);
    rchk(8'h28, 32'h2468_ace0);
  endtask

  task automatic t_irq;
    rchk(8'h48, 32'h2);
    wr(8'h48, 32'h3);
    wr(8'h4c, 32'h1);
    rchk(8'h4c, 32'h1);
    post_err(48'hffee_1234_5678, 16'hfc85);
    chk(32'(irq), 32'h1);
    wr(8'h48, 32'h1);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    wr(8'h38, 32'h0);
    wr(8'h3c, 32'h0);
    rchk(8'h38, 32'h1234_5678);
    rchk(8'h3c, 32'hfc85_ffee);
    wr(8'h4c, 32'h0);
    post_err(48'h0001_0000_0010, 16'h0041);
    chk(32'(irq), 32'h0);
    rchk(8'h48, 32'h1);
    rchk(8'h38, 32'h0000_0010);
    rchk(8'h3c, 32'h0041_0001);
  endtask

  task automatic results;
    $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset_values;
    t_rom;
    t_firmware;
    t_resets;
    t_eeprom;
    t_irq;
    results;
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    #100us;
    fail_count++;
    results;
  end
endmodule // identity_address_regs_bench
